//--- hw/sscf_pkg.sv
// constants, types and register map of the slave serial port configuration and fifo level block
// Overview of operation
// - port enabled blocks writes to control registers
// - phase 0: gap bit picks select level between frames
// - control word length is code plus one
// - output enable bit gates serial data output
// - transfer mode marks valid data, shifting unchanged
// - polarity bit gives serial clock idle level
// - phase bit picks first or second sampling edge outside frame pulse and three-wire
// - protocol field picks standard, frame pulse, three-wire
// - data frame length is code plus one
// - three-wire direction bit: receive or transmit data
// - three-wire sequence bit: single or continuous frames
// - tx threshold flag when level at or below
// - rx threshold flag when level at or above
// - tx level field shows tx fifo count
// - rx level field shows rx fifo count
// - unprogrammed threshold acts as full fifo capacity
package sscf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] SSCF_OFF_CTRL_MAIN  = 8'h00;
  localparam logic [7:0] SSCF_OFF_PORT_EN    = 8'h08;
  localparam logic [7:0] SSCF_OFF_THREE_WIRE = 8'h0c;
  localparam logic [7:0] SSCF_OFF_TX_THR     = 8'h18;
  localparam logic [7:0] SSCF_OFF_RX_THR     = 8'h1c;
  localparam logic [7:0] SSCF_OFF_TX_LVL     = 8'h20;
  localparam logic [7:0] SSCF_OFF_RX_LVL     = 8'h24;

  // field positions
  localparam int SSCF_POS_GAP      = 24;
  localparam int SSCF_POS_CTRL_LEN = 12;
  localparam int SSCF_POS_OUT_EN   = 10;
  localparam int SSCF_POS_TMODE    = 8;
  localparam int SSCF_POS_CLOCK_IDLE_LEVEL     = 7;
  localparam int SSCF_POS_CLOCK_SAMPLE_PHASE     = 6;
  localparam int SSCF_POS_PROTO    = 4;
  localparam int SSCF_POS_DFS      = 0;
  localparam int SSCF_POS_DIR      = 1;
  localparam int SSCF_POS_SEQ      = 0;
  localparam int SSCF_POS_EN       = 0;

  // reset values
  localparam logic [31:0] SSCF_RST_CTRL_MAIN = 32'h01000007;
  localparam logic [1:0]  SSCF_RST_THR       = 2'h0;

  // fifo shape and thresholds
  localparam int         SSCF_DATA_W      = 16;
  localparam int         SSCF_FIFO_DEPTH  = 4;
  localparam int         SSCF_LVL_W       = 3;
  localparam logic [2:0] SSCF_THR_DEFAULT = 3'h4;

  // protocol and transfer mode codes
  localparam logic [1:0] SSCF_PROTO_SPI = 2'h0;
  localparam logic [1:0] SSCF_PROTO_SSP = 2'h1;
  localparam logic [1:0] SSCF_PROTO_3W  = 2'h2;
  localparam logic [1:0] SSCF_MODE_TX   = 2'h1;
  localparam logic [1:0] SSCF_MODE_RX   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic       select_gap_toggle;
    logic [3:0] control_word_length;
    logic       slave_output_enable;
    logic [1:0] transfer_direction_mode;
    logic       clock_idle_level;
    logic       clock_sample_phase;
    logic [1:0] frame_protocol_select;
    logic [3:0] data_frame_size;
  } sscf_cfg_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sscf_reg_req_t;

  typedef enum logic [3:0] {
    SSCF_ST_IDLE = 4'h1,
    SSCF_ST_CTRL = 4'h2,
    SSCF_ST_DATA = 4'h4,
    SSCF_ST_GAP  = 4'h8
  } sscf_state_t;

  // unpack the main control word into its fields
  function automatic sscf_cfg_t sscf_cfg_from_word(input logic [31:0] w);
    sscf_cfg_t c;
    c.select_gap_toggle       = w[SSCF_POS_GAP];
    c.control_word_length     = w[SSCF_POS_CTRL_LEN +: 4];
    c.slave_output_enable     = w[SSCF_POS_OUT_EN];
    c.transfer_direction_mode = w[SSCF_POS_TMODE +: 2];
    c.clock_idle_level        = w[SSCF_POS_CLOCK_IDLE_LEVEL];
    c.clock_sample_phase      = w[SSCF_POS_CLOCK_SAMPLE_PHASE];
    c.frame_protocol_select   = w[SSCF_POS_PROTO +: 2];
    c.data_frame_size         = w[SSCF_POS_DFS +: 4];
    return c;
  endfunction

  // pack the fields back, reserved bits read as zero
  function automatic logic [31:0] sscf_cfg_to_word(input sscf_cfg_t c);
    logic [31:0] w;
    w                           = 32'h00000000;
    w[SSCF_POS_GAP]             = c.select_gap_toggle;
    w[SSCF_POS_CTRL_LEN +: 4]   = c.control_word_length;
    w[SSCF_POS_OUT_EN]          = c.slave_output_enable;
    w[SSCF_POS_TMODE +: 2]      = c.transfer_direction_mode;
    w[SSCF_POS_CLOCK_IDLE_LEVEL]            = c.clock_idle_level;
    w[SSCF_POS_CLOCK_SAMPLE_PHASE]            = c.clock_sample_phase;
    w[SSCF_POS_PROTO +: 2]      = c.frame_protocol_select;
    w[SSCF_POS_DFS +: 4]        = c.data_frame_size;
    return w;
  endfunction

endpackage

//--- hw/sscf_fifo.sv
// four-entry data fifo with registered count, full and empty
`timescale 1ns/10ps
module sscf_fifo import sscf_pkg::*; (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // fill side
  input  wire logic                   push,
  input  wire logic [SSCF_DATA_W-1:0] push_data,
  // drain side
  input  wire logic                   pop,
  output logic      [SSCF_DATA_W-1:0] head,
  // level
  output logic      [SSCF_LVL_W-1:0]  count,
  output logic                        full,
  output logic                        empty
);

  logic [SSCF_DATA_W-1:0] mem [SSCF_FIFO_DEPTH];
  logic [1:0]             wr_ptr;
  logic [1:0]             rd_ptr;
  logic                   do_push;
  logic                   do_pop;
  logic [SSCF_LVL_W-1:0]  next_count;

  // a push into a full fifo or a pop from an empty one is dropped
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign head    = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = count + 3'h1;
    end else if (do_pop && !do_push) begin
      next_count = count - 3'h1;
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // pointers and level flags, full and empty kept as flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 3'h0;
      full   <= 1'b0;
      empty  <= 1'b1;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      count <= next_count;
      full  <= (next_count == SSCF_THR_DEFAULT);
      empty <= (next_count == 3'h0);
    end
  end

endmodule

//--- hw/sscf_top.sv
// slave serial port: configuration registers, fifo levels and frame shifter
`timescale 1ns/10ps
module sscf_top import sscf_pkg::*; (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // register port
  input  wire sscf_reg_req_t          reg_req,
  output logic      [31:0]            reg_rdata,
  // transmit data side
  input  wire logic                   tx_push,
  input  wire logic [SSCF_DATA_W-1:0] tx_data,
  output logic                        tx_full,
  // receive data side
  input  wire logic                   rx_pop,
  output logic      [SSCF_DATA_W-1:0] rx_data,
  output logic                        rx_valid,
  // threshold conditions
  output logic                        tx_threshold_hit,
  output logic                        rx_threshold_hit,
  // serial pins
  input  wire logic                   sclk,
  input  wire logic                   slave_select_n,
  input  wire logic                   mosi,
  output logic                        miso_out,
  output logic                        miso_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  sscf_cfg_t              cfg;
  logic                   port_en;
  logic                   three_wire_data_direction;
  logic                   three_wire_sequence_mode;
  logic [1:0]             tx_threshold_level;
  logic [1:0]             rx_threshold_level;
  logic                   tx_thr_set;
  logic                   rx_thr_set;
  logic [2:0]             tx_thr_eff;
  logic [2:0]             rx_thr_eff;
  logic [31:0]            next_rdata;

  logic [2:0]             sync_a;
  logic [2:0]             sync_b;
  logic                   sclk_s;
  logic                   ss_n_s;
  logic                   mosi_s;
  logic                   sclk_last;
  logic                   ss_last;
  logic                   rise;
  logic                   fall;
  logic                   lead;
  logic                   trail;
  logic                   sample_edge;
  logic                   shift_edge;

  sscf_state_t            state;
  logic [3:0]             bit_cnt;
  logic [SSCF_DATA_W-1:0] tx_sh;
  logic [SSCF_DATA_W-1:0] rx_sh;
  logic                   is_3w;
  logic                   is_ssp;
  logic                   sel_active;
  logic                   start;
  logic                   sel_lost;
  logic [3:0]             len_last;
  logic                   frame_done;
  logic                   stay;
  logic                   next_is_data;
  logic                   load_data;
  logic                   data_is_tx;
  logic                   data_is_rx;
  logic                   tx_pop;
  logic                   rx_push;
  logic [SSCF_DATA_W-1:0] load_word;

  logic [SSCF_DATA_W-1:0] tx_head;
  logic [SSCF_LVL_W-1:0]  tx_entry_count;
  logic                   tx_empty;
  logic [SSCF_DATA_W-1:0] rx_head;
  logic [SSCF_LVL_W-1:0]  rx_entry_count;
  logic                   rx_empty;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  // control writes are dropped while enabled so the shifter never sees a
  // format change in the middle of a frame
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg                       <= sscf_cfg_from_word(SSCF_RST_CTRL_MAIN);
      port_en                   <= 1'b0;
      three_wire_data_direction <= 1'b0;
      three_wire_sequence_mode  <= 1'b0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == SSCF_OFF_CTRL_MAIN && !port_en) begin
        cfg <= sscf_cfg_from_word(reg_req.wdata);
      end
      if (reg_req.addr == SSCF_OFF_THREE_WIRE && !port_en) begin
        three_wire_data_direction <= reg_req.wdata[SSCF_POS_DIR];
        three_wire_sequence_mode  <= reg_req.wdata[SSCF_POS_SEQ];
      end
      if (reg_req.addr == SSCF_OFF_PORT_EN) begin
        port_en <= reg_req.wdata[SSCF_POS_EN];
      end
    end
  end

  // thresholds, writable at any time; the set flags remember a first write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_threshold_level <= SSCF_RST_THR;
      rx_threshold_level <= SSCF_RST_THR;
      tx_thr_set         <= 1'b0;
      rx_thr_set         <= 1'b0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == SSCF_OFF_TX_THR) begin
        tx_threshold_level <= reg_req.wdata[1:0];
        tx_thr_set         <= 1'b1;
      end
      if (reg_req.addr == SSCF_OFF_RX_THR) begin
        rx_threshold_level <= reg_req.wdata[1:0];
        rx_thr_set         <= 1'b1;
      end
    end
  end

  // unprogrammed thresholds stand at fifo capacity
  assign tx_thr_eff = tx_thr_set ? {1'b0, tx_threshold_level} : SSCF_THR_DEFAULT;
  assign rx_thr_eff = rx_thr_set ? {1'b0, rx_threshold_level} : SSCF_THR_DEFAULT;

  ////////////////////////////////////////////////////////////////////////////
  // register reads, unmapped offsets answer zero
  always_comb begin
    next_rdata = 32'h00000000;
    case (reg_req.addr)
      SSCF_OFF_CTRL_MAIN:  next_rdata = sscf_cfg_to_word(cfg);
      SSCF_OFF_PORT_EN:    next_rdata[SSCF_POS_EN] = port_en;
      SSCF_OFF_THREE_WIRE: begin
        next_rdata[SSCF_POS_DIR] = three_wire_data_direction;
        next_rdata[SSCF_POS_SEQ] = three_wire_sequence_mode;
      end
      SSCF_OFF_TX_THR:     next_rdata[1:0] = tx_threshold_level;
      SSCF_OFF_RX_THR:     next_rdata[1:0] = rx_threshold_level;
      SSCF_OFF_TX_LVL:     next_rdata[2:0] = tx_entry_count;
      SSCF_OFF_RX_LVL:     next_rdata[2:0] = rx_entry_count;
      default:             next_rdata = 32'h00000000;
    endcase
  end

  // read data lands one edge after the read strobe and then holds
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: sync_a feeds only sync_b
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync_a    <= 3'h2;
      sync_b    <= 3'h2;
      sclk_last <= 1'b0;
      ss_last   <= 1'b1;
    end else begin
      sync_a    <= {sclk, slave_select_n, mosi};
      sync_b    <= sync_a;
      sclk_last <= sync_b[2];
      ss_last   <= sync_b[1];
    end
  end

  assign sclk_s = sync_b[2];
  assign ss_n_s = sync_b[1];
  assign mosi_s = sync_b[0];

  // clock edges relative to the idle level
  assign rise  = sclk_s && !sclk_last;
  assign fall  = !sclk_s && sclk_last;
  assign lead  = cfg.clock_idle_level ? fall : rise;
  assign trail = cfg.clock_idle_level ? rise : fall;

  // frame pulse format samples on falling, three-wire on rising edges
  always_comb begin
    case (cfg.frame_protocol_select)
      SSCF_PROTO_SSP: begin
        sample_edge = fall;
        shift_edge  = rise;
      end
      SSCF_PROTO_3W: begin
        sample_edge = rise;
        shift_edge  = fall;
      end
      default: begin
        sample_edge = cfg.clock_sample_phase ? trail : lead;
        shift_edge  = cfg.clock_sample_phase ? lead : trail;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame control terms
  assign is_3w      = (cfg.frame_protocol_select == SSCF_PROTO_3W);
  assign is_ssp     = (cfg.frame_protocol_select == SSCF_PROTO_SSP);
  assign sel_active = is_ssp ? ss_n_s : !ss_n_s;
  // frame pulse format starts when the one-clock pulse ends
  assign start      = port_en && (is_ssp ? (!ss_n_s && ss_last) : !ss_n_s);
  assign sel_lost   = !is_ssp && ss_n_s;
  assign len_last   = (state == SSCF_ST_CTRL) ? cfg.control_word_length
                                              : cfg.data_frame_size;
  assign frame_done = (state == SSCF_ST_CTRL || state == SSCF_ST_DATA) && !sel_lost &&
                      sample_edge && (bit_cnt == len_last);

  // whether the next data frame follows without a select gap
  always_comb begin
    case (cfg.frame_protocol_select)
      SSCF_PROTO_SPI: stay = cfg.clock_sample_phase || !cfg.select_gap_toggle;
      SSCF_PROTO_3W:  stay = three_wire_sequence_mode;
      default:        stay = 1'b0;
    endcase
  end

  // transfer mode only marks validity; the shifter runs the same either way
  assign data_is_tx   = is_3w ? three_wire_data_direction
                              : (cfg.transfer_direction_mode != SSCF_MODE_RX);
  assign data_is_rx   = is_3w ? !three_wire_data_direction
                              : (cfg.transfer_direction_mode != SSCF_MODE_TX);
  assign next_is_data = frame_done && (state == SSCF_ST_CTRL || stay);
  assign load_data    = (state == SSCF_ST_IDLE && start && !is_3w) || next_is_data;
  assign tx_pop       = load_data && data_is_tx && !tx_empty;
  assign load_word    = tx_pop ? tx_head : {SSCF_DATA_W{1'b0}};  // an empty fifo sends zeros
  assign rx_push      = frame_done && (state == SSCF_ST_DATA) && data_is_rx;

  ////////////////////////////////////////////////////////////////////////////
  // frame shifter
  // the shift edge before the first sample is skipped so the preloaded
  // first bit stays on the line for phase 1
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state   <= SSCF_ST_IDLE;
      bit_cnt <= 4'h0;
      tx_sh   <= {SSCF_DATA_W{1'b0}};
      rx_sh   <= {SSCF_DATA_W{1'b0}};
    end else if (!port_en) begin
      state   <= SSCF_ST_IDLE;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        SSCF_ST_IDLE: begin
          if (start) begin
            state   <= is_3w ? SSCF_ST_CTRL : SSCF_ST_DATA;
            bit_cnt <= 4'h0;
            tx_sh   <= load_word;
            rx_sh   <= {SSCF_DATA_W{1'b0}};  // no bits left over from an aborted frame
          end
        end
        SSCF_ST_CTRL, SSCF_ST_DATA: begin
          if (sel_lost) begin
            state <= SSCF_ST_IDLE;
          end else if (sample_edge) begin
            rx_sh <= frame_done ? {SSCF_DATA_W{1'b0}} : {rx_sh[SSCF_DATA_W-2:0], mosi_s};
            if (frame_done) begin
              bit_cnt <= 4'h0;
              if (next_is_data) begin
                state <= SSCF_ST_DATA;
                tx_sh <= load_word;
              end else begin
                state <= is_ssp ? SSCF_ST_IDLE : SSCF_ST_GAP;
              end
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end else if (shift_edge && bit_cnt != 4'h0) begin
            tx_sh <= {tx_sh[SSCF_DATA_W-2:0], 1'b0};
          end
        end
        SSCF_ST_GAP: begin
          if (!sel_active) begin
            state <= SSCF_ST_IDLE;
          end
        end
        default: state <= SSCF_ST_IDLE;
      endcase
    end
  end

  // serial output, gated by the output enable bit
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      miso_out <= tx_sh[cfg.data_frame_size];
      miso_oe  <= port_en && cfg.slave_output_enable &&
                  (state == SSCF_ST_DATA) && (!is_3w || three_wire_data_direction);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifos
  sscf_fifo u_tx_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .push      (tx_push),
    .push_data (tx_data),
    .pop       (tx_pop),
    .head      (tx_head),
    .count     (tx_entry_count),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  // received word is the low bits of the shifter, right aligned
  sscf_fifo u_rx_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .push      (rx_push),
    .push_data ({rx_sh[SSCF_DATA_W-2:0], mosi_s}),
    .pop       (rx_pop && !rx_empty),
    .head      (rx_head),
    .count     (rx_entry_count),
    .full      (),
    .empty     (rx_empty)
  );

  // receive side read-out, valid one edge after the pop
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_data  <= {SSCF_DATA_W{1'b0}};
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= rx_pop && !rx_empty;
      if (rx_pop && !rx_empty) begin
        rx_data <= rx_head;
      end
    end
  end

  // threshold conditions as levels
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_threshold_hit <= 1'b0;
      rx_threshold_hit <= 1'b0;
    end else begin
      tx_threshold_hit <= (tx_entry_count <= tx_thr_eff);
      rx_threshold_hit <= (rx_entry_count >= rx_thr_eff);
    end
  end

endmodule

//--- dv/sscf_monitor.sv
// concurrent checks on the ports of the slave serial port block
`timescale 1ns/10ps
module sscf_monitor import sscf_pkg::*; (
  // clock and reset
  input wire logic          ref_clk,
  input wire logic          reset,
  // register port
  input wire sscf_reg_req_t reg_req,
  input wire logic [31:0]   reg_rdata,
  // data sides
  input wire logic          tx_push,
  input wire logic          tx_full,
  input wire logic          rx_pop,
  input wire logic          rx_valid,
  // serial pins
  input wire logic          slave_select_n,
  input wire logic          miso_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // read data and field widths
  rdata_hold_a: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  txlvl_field_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == SSCF_OFF_TX_LVL
    |-> reg_rdata[31:3] == 29'h0 && reg_rdata[2:0] <= 3'h4) else $error("tx level read out of range");
  rxlvl_field_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == SSCF_OFF_RX_LVL
    |-> reg_rdata[31:3] == 29'h0 && reg_rdata[2:0] <= 3'h4) else $error("rx level read out of range");
  thr_field_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == SSCF_OFF_TX_THR
    |-> reg_rdata[31:2] == 30'h0) else $error("tx threshold reserved bits set");
  en_field_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == SSCF_OFF_PORT_EN
    |-> reg_rdata[31:1] == 31'h0) else $error("enable reserved bits set");
  // a one-entry pop answer needs a pop, full needs a push
  rxvalid_cause_a: assert property (rx_valid |-> $past(rx_pop))
    else $error("rx valid without pop");
  txfull_cause_a: assert property ($rose(tx_full) |-> $past(tx_push))
    else $error("tx full rose without push");
  // a deselected slave lets go of its output once the select has settled
  oe_idle_a: assert property (slave_select_n [*6] |-> !miso_oe)
    else $error("output driven while deselected");
  cover property (rx_valid);
endmodule

bind sscf_top sscf_monitor mon (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .tx_push(tx_push), .tx_full(tx_full), .rx_pop(rx_pop), .rx_valid(rx_valid),
  .slave_select_n(slave_select_n), .miso_oe(miso_oe));

//--- dv/sscf_master.sv
// serial master model driving clock, select and data into the slave port
`timescale 1ns/10ps
module sscf_master (
  // serial pins
  output logic      sclk,
  output logic      slave_select_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    slave_select_n = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame of n bits msb first, 48 ns clock, parked at idle outside frames
  task automatic xfer(input logic pol, input logic pha, input int n, input logic [15:0] w,
                      output logic [15:0] r);
    r = 16'h0000;
    sclk = pol;
    #48 slave_select_n = 1'b0;
    if (!pha) mosi = w[n-1];
    #48;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = ~pol;
      if (pha) mosi = w[i];
      else r = {r[14:0], miso};
      #24 sclk = pol;
      if (pha) r = {r[14:0], miso};
      else if (i > 0) mosi = w[i-1];
      #24;
    end
    // select always rises between frames; mosi no longer holds its last bit
    slave_select_n = 1'b1;
    mosi = ~mosi;
    #100;
  endtask
endmodule

//--- dv/sscf_top_tb.sv
// self-checking bench of the slave serial port block
`timescale 1ns/10ps
module sscf_top_tb;
  import sscf_pkg::*;
  logic          ref_clk = 1'b0;
  logic          reset = 1'b1;
  sscf_reg_req_t req = '0;
  logic [31:0]   rdata;
  logic [15:0]   tx_data = 16'h0000;
  logic [15:0]   rx_data;
  logic [15:0]   got;
  logic          tx_push = 1'b0;
  logic          rx_pop = 1'b0;
  logic          tx_full, rx_valid, tx_thr, rx_thr, sclk, ss_n, mosi, mo, oe;
  logic          tgl = 1'b0;
  logic          oe_seen = 1'b0;
  int            miscompares = 0;
  int            num_checks = 0;
  // undriven miso wanders every cycle so a stale bit cannot pass
  wire           miso_w = oe ? mo : tgl;
  logic [7:0]    addrs [8] = '{8'h00, 8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h04};
  int            nb [4] = '{4, 16, 8, 5};

  // clock, wander pattern and output-enable watcher
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tgl <= ~tgl;
  always @(posedge ref_clk) if (oe) oe_seen <= 1'b1;

  sscf_top dut (.ref_clk(ref_clk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .tx_push(tx_push),
    .tx_data(tx_data), .tx_full(tx_full), .rx_pop(rx_pop), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_threshold_hit(tx_thr), .rx_threshold_hit(rx_thr), .sclk(sclk), .slave_select_n(ss_n),
    .mosi(mosi), .miso_out(mo), .miso_oe(oe));
  sscf_master m (.sclk(sclk), .slave_select_n(ss_n), .mosi(mosi), .miso(miso_w));

  ////////////////////////////////////////////////////////////////////////////
  // compare, register and data tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk) #1 req = '0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk) #1 req = '0;
    chk("register", e, rdata);
  endtask
  task automatic push(input logic [15:0] d);
    @(posedge ref_clk) #1 tx_data = d;
    tx_push = 1'b1;
    @(posedge ref_clk) #1 tx_push = 1'b0;
  endtask
  task automatic pop(input logic [15:0] e);
    @(posedge ref_clk) #1 rx_pop = 1'b1;
    @(posedge ref_clk) #1 rx_pop = 1'b0;
    chk("rx_valid", 32'h1, rx_valid);
    chk("rx_data", e, rx_data);
  endtask
  // reconfigure only with the port disabled
  task automatic cfg(input logic [31:0] w);
    wr(SSCF_OFF_PORT_EN, 32'h0);
    wr(SSCF_OFF_CTRL_MAIN, w);
    wr(SSCF_OFF_PORT_EN, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rc(addrs[i], i == 0 ? SSCF_RST_CTRL_MAIN : 32'h0);
    chk("tx_hit", 32'h1, tx_thr);
    chk("rx_hit", 32'h0, rx_thr);
  endtask
  task automatic t_lock;
    wr(SSCF_OFF_PORT_EN, 32'h1);
    wr(SSCF_OFF_CTRL_MAIN, 32'h000004c7);
    rc(SSCF_OFF_CTRL_MAIN, SSCF_RST_CTRL_MAIN);
    wr(SSCF_OFF_THREE_WIRE, 32'h3);
    rc(SSCF_OFF_THREE_WIRE, 32'h0);
    wr(SSCF_OFF_PORT_EN, 32'h0);
    wr(SSCF_OFF_THREE_WIRE, 32'h3);
    rc(SSCF_OFF_THREE_WIRE, 32'h3);
  endtask
  task automatic t_spi;
    logic [15:0] mk;
    for (int i = 0; i < 4; i++) begin
      mk = 16'hffff >> (16 - nb[i]);
      cfg(32'h00000400 | {24'h0, i[1], i[0], 2'b00, 4'(nb[i] - 1)});
      push(16'ha5c3 & mk);
      m.xfer(i[1], i[0], nb[i], 16'h5a3c & mk, got);
      chk("miso word", {16'h0, 16'ha5c3 & mk}, {16'h0, got});
      rc(SSCF_OFF_RX_LVL, 32'h1);
      pop(16'h5a3c & mk);
    end
  endtask
  task automatic t_modes;
    cfg(32'h00000507);
    push(16'h0081);
    m.xfer(1'b0, 1'b0, 8, 16'h0066, got);
    chk("miso word", 32'h81, {16'h0, got});
    rc(SSCF_OFF_RX_LVL, 32'h0);
    cfg(32'h00000207);
    push(16'h0042);
    oe_seen = 1'b0;
    m.xfer(1'b0, 1'b0, 8, 16'h0099, got);
    chk("oe seen", 32'h0, oe_seen);
    rc(SSCF_OFF_TX_LVL, 32'h1);
    pop(16'h0099);
  endtask
  task automatic t_off;
    wr(SSCF_OFF_PORT_EN, 32'h0);
    wr(SSCF_OFF_CTRL_MAIN, 32'h00000407);
    oe_seen = 1'b0;
    m.xfer(1'b0, 1'b0, 8, 16'h00aa, got);
    chk("oe seen", 32'h0, oe_seen);
    rc(SSCF_OFF_RX_LVL, 32'h0);
    rc(SSCF_OFF_TX_LVL, 32'h1);
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 4; i++) push(16'h0011 + 16'(i));
    rc(SSCF_OFF_TX_LVL, 32'h4);
    chk("tx_full", 32'h1, tx_full);
    chk("tx_hit", 32'h1, tx_thr);
    wr(SSCF_OFF_TX_THR, 32'h3);
    wr(SSCF_OFF_RX_THR, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("tx_hit", 32'h0, tx_thr);
    chk("rx_hit", 32'h1, rx_thr);
    rc(SSCF_OFF_TX_THR, 32'h3);
  endtask

  // three-wire: 3-bit control word, then the device sends the word left queued by t_modes
  task automatic t_3w;
    cfg(32'h00002427);
    m.xfer(1'b0, 1'b0, 11, 16'h0155, got);
    chk("miso word", 32'h42, {24'h0, got[7:0]});
    rc(SSCF_OFF_TX_LVL, 32'h0);
    rc(SSCF_OFF_RX_LVL, 32'h0);
  endtask

  // verdict and end of run
  task automatic summarize;
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_reset();
    t_lock();
    t_spi();
    t_modes();
    t_off();
    t_3w();
    t_fifo();
    summarize();
  end
  // watchdog well beyond the expected run of about eleven hundred cycles
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule
